// >>> design/dls_init_seq.sv
// Purpose: host sequencer bringing up both timing loops of the converter
// Assumes: device registers reached over a 4-wire serial port
// Notes:   waits are counted in system cycles covering the data-rate periods
// Notes on behaviour
// - delay loop control written 0x02 then 0x03 for search and track
// - wait 160 K data-rate periods before reading delay loop status
// - no delay lock: redo from config C write, three attempts, then fail
// - data interface clock must be present before receiver setup
// - write 0x72 to capture skew register, offset field two
// - receiver control written 0x00 before every enable attempt
// - receiver control then written 0x02, then 0x03
// - wait 135 K data-rate periods before reading receiver status
// - receiver not locked: advance phase bits 7:6, retry, three attempts
// - optional full-scale current writes to 0x06 and 0x07
// - optional operation mode write to 0x08
// - delay loop locked and tracking before receiver enable
`timescale 1ns/10ps
module dls_init_seq
  import dls_pkg::*;
#(
  parameter int FDATA_MHZ   = FDATA_MHZ_DEF,
  parameter int DLL_WAIT_CYC = (DLL_WAIT_PERIODS * SYS_CLK_MHZ + FDATA_MHZ - 1) / FDATA_MHZ,
  parameter int RX_WAIT_CYC  = (RX_WAIT_PERIODS * SYS_CLK_MHZ + FDATA_MHZ - 1) / FDATA_MHZ
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       data_clk_present,
  input  wire logic       cur_en,
  input  wire logic [7:0] cur_lo,
  input  wire logic [7:0] cur_hi,
  input  wire logic       mode_en,
  input  wire logic [7:0] mode_val,
  output logic            seq_busy,
  output logic            seq_done,
  output logic            dll_lock_fail,
  output logic            rx_lock_fail,
  output logic            spi_cs_n,
  output logic            spi_sclk,
  output logic            spi_mosi,
  input  wire logic       spi_miso
);
  typedef struct packed {
    dls_state_e         st;
    logic [4:0]         step;
    logic [1:0]         att;
    logic [WAIT_W-1:0]  cnt;
    logic               go;
    logic               rw;
    logic [6:0]         addr;
    logic [7:0]         wdata;
    logic [7:0]         phase;
    logic               busy;
    logic               done;
    logic               dll_fail;
    logic               rx_fail;
    logic               dclk_s1;
    logic               dclk_s2;
  } dls_seq_s;

  dls_seq_s   r_r, r_nxt;
  logic       spi_done;
  logic [7:0] spi_rdata;
  dls_kind_e  op_kind;
  logic [6:0] op_addr;
  logic [7:0] op_data;
  logic       op_skip;

  // step table
  always_comb begin
    op_kind = K_WR;
    op_addr = A_DL_CTRL;
    op_data = V_OFF;
    op_skip = 1'b0;
    unique case (r_r.step)
      5'd0:  begin op_addr = A_DL_CFG_A; op_data = V_DL_CFG_A; end
      5'd1:  begin op_addr = A_DL_CFG_B; op_data = V_DL_CFG_B; end
      5'd2:  begin op_addr = A_DL_CFG_C; op_data = V_DL_CFG_C; end
      5'd3:  begin op_addr = A_DL_CTRL;  op_data = V_EN_LOOP; end
      5'd4:  begin op_addr = A_DL_CTRL;  op_data = V_EN_TRACK; end
      5'd5:  op_kind = K_WAIT;
      5'd6:  begin op_kind = K_RD; op_addr = A_DL_STAT; end
      5'd7:  begin op_addr = A_RX_SKEW; op_data = V_SKEW; end
      5'd8:  begin op_addr = A_RX_CTRL; op_data = V_OFF; end
      5'd9:  begin op_addr = A_RX_CTRL; op_data = V_EN_LOOP; end
      5'd10: begin op_addr = A_RX_CTRL; op_data = V_EN_TRACK; end
      5'd11: op_kind = K_WAIT;
      5'd12: begin op_kind = K_RD; op_addr = A_RX_STAT; end
      5'd13: begin op_kind = K_RD; op_addr = A_RX_PHASE; end
      5'd14: begin
        op_addr = A_RX_PHASE;
        op_data = {r_r.phase[7:PH_LSB] + 2'd1, r_r.phase[PH_LSB-1:0]};
      end
      5'd15: begin op_addr = A_CUR_LO; op_data = cur_lo; op_skip = !cur_en; end
      5'd16: begin op_addr = A_CUR_HI; op_data = cur_hi; op_skip = !cur_en; end
      5'd17: begin op_addr = A_OP_MODE; op_data = mode_val; op_skip = !mode_en; end
      default: op_kind = K_END;
    endcase
  end

  // sequencer
  always_comb begin
    r_nxt         = r_r;
    r_nxt.go      = 1'b0;
    r_nxt.dclk_s1 = data_clk_present;
    r_nxt.dclk_s2 = r_r.dclk_s1;
    unique case (r_r.st)
      SQ_IDLE, SQ_DONE, SQ_FAIL: begin
        if (start) begin
          r_nxt.st       = SQ_ISSUE;
          r_nxt.step     = 5'd0;
          r_nxt.att      = 2'd0;
          r_nxt.busy     = 1'b1;
          r_nxt.done     = 1'b0;
          r_nxt.dll_fail = 1'b0;
          r_nxt.rx_fail  = 1'b0;
        end
      end
      SQ_ISSUE: begin
        if (op_skip) begin
          r_nxt.step = r_r.step + 5'd1;
        end else if (op_kind == K_WAIT) begin
          r_nxt.st  = SQ_WAIT;
          r_nxt.cnt = (r_r.step == ST_DL_WAIT) ? WAIT_W'(DLL_WAIT_CYC - 1) : WAIT_W'(RX_WAIT_CYC - 1);
        end else if (op_kind == K_END) begin
          r_nxt.st   = SQ_DONE;
          r_nxt.busy = 1'b0;
          r_nxt.done = 1'b1;
        end else if (r_r.step != ST_SKEW || r_r.dclk_s2) begin
          r_nxt.st    = SQ_BUSY;
          r_nxt.go    = 1'b1;
          r_nxt.rw    = (op_kind == K_RD);
          r_nxt.addr  = op_addr;
          r_nxt.wdata = op_data;
        end
      end
      SQ_WAIT: begin
        if (r_r.cnt == '0) begin
          r_nxt.st   = SQ_ISSUE;
          r_nxt.step = r_r.step + 5'd1;
        end else begin
          r_nxt.cnt = r_r.cnt - WAIT_W'(1);
        end
      end
      SQ_BUSY: begin
        if (spi_done) begin
          r_nxt.st   = SQ_ISSUE;
          r_nxt.step = r_r.step + 5'd1;
          if (r_r.step == ST_DL_CHECK) begin
            if (spi_rdata == V_DL_LOCK) begin
              r_nxt.att = 2'd0;
            end else if (r_r.att == ATT_LAST) begin
              r_nxt.st       = SQ_FAIL;
              r_nxt.busy     = 1'b0;
              r_nxt.dll_fail = 1'b1;
            end else begin
              r_nxt.att  = r_r.att + 2'd1;
              r_nxt.step = ST_DL_RETRY;
            end
          end else if (r_r.step == ST_RX_CHECK) begin
            if (spi_rdata == V_RX_LOCK) begin
              r_nxt.step = ST_CUR_LO;
            end else if (r_r.att == ATT_LAST) begin
              r_nxt.st      = SQ_FAIL;
              r_nxt.busy    = 1'b0;
              r_nxt.rx_fail = 1'b1;
            end
          end else if (r_r.step == ST_PH_RD) begin
            r_nxt.phase = spi_rdata;
          end else if (r_r.step == ST_PH_WR) begin
            r_nxt.att  = r_r.att + 2'd1;
            r_nxt.step = ST_RX_RETRY;
          end
        end
      end
      default: r_nxt.st = SQ_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r_r    <= '0;
      r_r.st <= SQ_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  // serial port
  dls_spi_master u_spi (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .go       (r_r.go),
    .rw       (r_r.rw),
    .addr     (r_r.addr),
    .wdata    (r_r.wdata),
    .done     (spi_done),
    .rdata    (spi_rdata),
    .spi_cs_n (spi_cs_n),
    .spi_sclk (spi_sclk),
    .spi_mosi (spi_mosi),
    .spi_miso (spi_miso)
  );

  assign seq_busy      = r_r.busy;
  assign seq_done      = r_r.done;
  assign dll_lock_fail = r_r.dll_fail;
  assign rx_lock_fail  = r_r.rx_fail;

  // helper: last write issued, delay loop lock seen
  logic [6:0] last_addr_r;
  logic [7:0] last_data_r;
  logic       dl_ok_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      last_addr_r <= 7'h00;
      last_data_r <= 8'h00;
      dl_ok_r     <= 1'b0;
    end else begin
      if (r_r.go && !r_r.rw) begin
        last_addr_r <= r_r.addr;
        last_data_r <= r_r.wdata;
      end
      if (start && !r_r.busy) begin
        dl_ok_r <= 1'b0;
      end else if (spi_done && r_r.step == ST_DL_CHECK && spi_rdata == V_DL_LOCK) begin
        dl_ok_r <= 1'b1;
      end
    end
  end

  sequence s_wait_end(logic [4:0] stp);
    r_r.st == SQ_WAIT && r_r.step == stp && r_r.cnt == '0 ##1 r_r.st == SQ_ISSUE;
  endsequence

  property p_dl_track;
    @(posedge sys_clk) disable iff (!rst_n)
      r_r.go && r_r.addr == A_DL_CTRL && r_r.wdata == V_EN_TRACK |-> last_addr_r == A_DL_CTRL && last_data_r == V_EN_LOOP;
  endproperty
  a_dl_track: assert property (p_dl_track) else $error("track written without loop enable");

  property p_dl_wait;
    @(posedge sys_clk) disable iff (!rst_n)
      s_wait_end(ST_DL_WAIT) |=> r_r.go && r_r.rw && r_r.addr == A_DL_STAT;
  endproperty
  a_dl_wait: assert property (p_dl_wait) else $error("delay status not read after wait");

  property p_dl_fail;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(r_r.dll_fail) |-> $past(r_r.att) == ATT_LAST && $past(spi_rdata) != V_DL_LOCK;
  endproperty
  a_dl_fail: assert property (p_dl_fail) else $error("delay fail before third attempt");

  property p_skew_dci;
    @(posedge sys_clk) disable iff (!rst_n)
      r_r.go && r_r.addr == A_RX_SKEW |-> $past(r_r.dclk_s2) && !r_r.rw && r_r.wdata == V_SKEW;
  endproperty
  a_skew_dci: assert property (p_skew_dci) else $error("skew write bad or clock absent");

  property p_rx_off;
    @(posedge sys_clk) disable iff (!rst_n)
      r_r.go && r_r.addr == A_RX_CTRL && r_r.wdata == V_EN_LOOP |-> last_addr_r == A_RX_CTRL && last_data_r == V_OFF;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receiver enabled without disable");

  property p_rx_track;
    @(posedge sys_clk) disable iff (!rst_n)
      r_r.go && r_r.addr == A_RX_CTRL && r_r.wdata == V_EN_TRACK |-> last_data_r == V_EN_LOOP;
  endproperty
  a_rx_track: assert property (p_rx_track) else $error("receiver track without loop enable");

  property p_rx_wait;
    @(posedge sys_clk) disable iff (!rst_n)
      s_wait_end(ST_RX_WAIT) |=> r_r.go && r_r.rw && r_r.addr == A_RX_STAT;
  endproperty
  a_rx_wait: assert property (p_rx_wait) else $error("receiver status not read after wait");

  property p_phase;
    @(posedge sys_clk) disable iff (!rst_n)
      r_r.go && !r_r.rw && r_r.addr == A_RX_PHASE |-> r_r.wdata[7:PH_LSB] == r_r.phase[7:PH_LSB] + 2'd1;
  endproperty
  a_phase: assert property (p_phase) else $error("phase not advanced by one");

  property p_dl_first;
    @(posedge sys_clk) disable iff (!rst_n)
      r_r.go && r_r.addr == A_RX_CTRL |-> dl_ok_r;
  endproperty
  a_dl_first: assert property (p_dl_first) else $error("receiver touched before delay lock");

  property p_rx_fail;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(r_r.rx_fail) |-> !r_r.dll_fail && $past(r_r.att) == ATT_LAST;
  endproperty
  a_rx_fail: assert property (p_rx_fail) else $error("receiver fail flag wrong");
endmodule : dls_init_seq

// >>> design/dls_pkg.sv
// Purpose: shared constants for the converter start-up sequencer
// Assumes: 100 MHz system clock, 8-bit registers behind a 16-bit serial frame
// Notes:   frame is {read flag, 7-bit address, 8-bit data}, msb first
package dls_pkg;
  // timing
  localparam int SYS_CLK_MHZ      = 100;
  localparam int FDATA_MHZ_DEF    = 1250;     // data rate default, MHz
  localparam int DLL_WAIT_PERIODS = 160000;   // data-rate periods
  localparam int RX_WAIT_PERIODS  = 135000;   // data-rate periods
  localparam int SCLK_HALF        = 4;        // system cycles per half serial clock
  localparam int WAIT_W           = 24;
  // device register map
  localparam logic [6:0] A_CUR_LO   = 7'h06;
  localparam logic [6:0] A_CUR_HI   = 7'h07;
  localparam logic [6:0] A_OP_MODE  = 7'h08;
  localparam logic [6:0] A_RX_CTRL  = 7'h10;
  localparam logic [6:0] A_RX_SKEW  = 7'h13;
  localparam logic [6:0] A_RX_PHASE = 7'h14;
  localparam logic [6:0] A_RX_STAT  = 7'h21;
  localparam logic [6:0] A_DL_CTRL  = 7'h26;
  localparam logic [6:0] A_DL_CFG_A = 7'h27;
  localparam logic [6:0] A_DL_CFG_B = 7'h28;
  localparam logic [6:0] A_DL_CFG_C = 7'h29;
  localparam logic [6:0] A_DL_STAT  = 7'h2a;
  // values written and expected
  localparam logic [7:0] V_DL_CFG_A = 8'h44;
  localparam logic [7:0] V_DL_CFG_B = 8'h6c;
  localparam logic [7:0] V_DL_CFG_C = 8'hcb;
  localparam logic [7:0] V_EN_LOOP  = 8'h02;
  localparam logic [7:0] V_EN_TRACK = 8'h03;
  localparam logic [7:0] V_OFF      = 8'h00;
  localparam logic [7:0] V_SKEW     = 8'h72;
  localparam logic [7:0] V_DL_LOCK  = 8'h01;
  localparam logic [7:0] V_RX_LOCK  = 8'h09;
  localparam int         PH_LSB     = 6;
  localparam logic [1:0] ATT_LAST   = 2'd2;   // third attempt
  // step indices
  localparam logic [4:0] ST_DL_RETRY = 5'd2;
  localparam logic [4:0] ST_DL_WAIT  = 5'd5;
  localparam logic [4:0] ST_DL_CHECK = 5'd6;
  localparam logic [4:0] ST_SKEW     = 5'd7;
  localparam logic [4:0] ST_RX_RETRY = 5'd8;
  localparam logic [4:0] ST_RX_WAIT  = 5'd11;
  localparam logic [4:0] ST_RX_CHECK = 5'd12;
  localparam logic [4:0] ST_PH_RD    = 5'd13;
  localparam logic [4:0] ST_PH_WR    = 5'd14;
  localparam logic [4:0] ST_CUR_LO   = 5'd15;
  localparam logic [4:0] ST_CUR_HI   = 5'd16;
  localparam logic [4:0] ST_MODE     = 5'd17;

  typedef enum logic [2:0] {
    SQ_IDLE  = 3'b000,
    SQ_ISSUE = 3'b001,
    SQ_BUSY  = 3'b011,
    SQ_WAIT  = 3'b010,
    SQ_DONE  = 3'b110,
    SQ_FAIL  = 3'b111
  } dls_state_e;

  typedef enum logic [1:0] {K_WR = 2'd0, K_RD = 2'd1, K_WAIT = 2'd2, K_END = 2'd3} dls_kind_e;
endpackage : dls_pkg

// >>> design/dls_spi_master.sv
// Purpose: one 16-bit serial frame per request, write or read
// Assumes: serial clock idles low, data out on falling edge, sampled on rising
// Notes:   requests while a frame runs are ignored
`timescale 1ns/10ps
module dls_spi_master
  import dls_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic       rw,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] wdata,
  output logic            done,
  output logic [7:0]      rdata,
  output logic            spi_cs_n,
  output logic            spi_sclk,
  output logic            spi_mosi,
  input  wire logic       spi_miso
);
  typedef struct packed {
    logic        cs_n;
    logic        sclk;
    logic        mosi;
    logic        done;
    logic [15:0] tx;
    logic [7:0]  rx;
    logic [3:0]  bitc;
    logic [2:0]  div;
    logic        s1;
    logic        s2;
  } dls_spi_s;

  dls_spi_s r_r, r_nxt;

  // frame engine
  always_comb begin
    r_nxt      = r_r;
    r_nxt.done = 1'b0;
    r_nxt.s1   = spi_miso;
    r_nxt.s2   = r_r.s1;
    if (r_r.cs_n) begin
      if (go) begin
        r_nxt.cs_n = 1'b0;
        r_nxt.tx   = {rw, addr, wdata};
        r_nxt.mosi = rw;
        r_nxt.bitc = 4'd0;
        r_nxt.div  = 3'd0;
      end
    end else if (r_r.div == 3'(SCLK_HALF - 1)) begin
      r_nxt.div = 3'd0;
      if (!r_r.sclk) begin
        r_nxt.sclk = 1'b1;
        r_nxt.rx   = {r_r.rx[6:0], r_r.s2};   // sample on rising edge
      end else begin
        r_nxt.sclk = 1'b0;
        if (r_r.bitc == 4'd15) begin
          r_nxt.cs_n = 1'b1;
          r_nxt.done = 1'b1;
        end else begin
          r_nxt.bitc = r_r.bitc + 4'd1;
          r_nxt.tx   = {r_r.tx[14:0], 1'b0};
          r_nxt.mosi = r_r.tx[14];
        end
      end
    end else begin
      r_nxt.div = r_r.div + 3'd1;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r_r      <= '0;
      r_r.cs_n <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign done     = r_r.done;
  assign rdata    = r_r.rx;
  assign spi_cs_n = r_r.cs_n;
  assign spi_sclk = r_r.sclk;
  assign spi_mosi = r_r.mosi;
endmodule : dls_spi_master

// >>> verification/dls_dev_model.sv
// Purpose: behavioural converter serial port, register file and loop status
// Assumes: 16-bit frame {read flag, address, data}, msb first, sampled on rising sclk
// Notes:   loop status shows lock from the attempt set by the bench, 0 means never
`timescale 1ns/10ps
module dls_dev_model
  import dls_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  dll_ok_at,
  input  wire logic [1:0]  rx_ok_at,
  input  wire logic [7:0]  ph_init,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sclk,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             frm_valid,
  output logic [15:0]      frm
);
  logic [7:0]  mem [0:127];
  logic [15:0] sh_r;
  logic [4:0]  cnt_r;
  logic [7:0]  rb_r;
  logic [2:0]  dll_rd_r;
  logic [2:0]  rx_rd_r;
  logic        sclk_q;
  logic        cs_q;
  logic [7:0]  look;

  // value of the addressed register; non-lock codes are supersets of lock codes
  always_comb begin
    case (sh_r[6:0])
      A_DL_STAT: look = (dll_ok_at != 2'd0 && dll_rd_r + 3'd1 >= {1'b0, dll_ok_at}) ? V_DL_LOCK : 8'h03;
      A_RX_STAT: look = (rx_ok_at != 2'd0 && rx_rd_r + 3'd1 >= {1'b0, rx_ok_at}) ? V_RX_LOCK : 8'h0b;
      default:   look = mem[sh_r[6:0]];
    endcase
  end

  // serial slave: shift in on rising sclk, drive read data after falling sclk
  always @(posedge sys_clk) begin
    sclk_q <= spi_sclk;
    cs_q <= spi_cs_n;
    frm_valid <= 1'b0;
    if (!rst_n) begin
      sh_r <= 16'h0000;
      cnt_r <= 5'd0;
      rb_r <= 8'h00;
      dll_rd_r <= 3'd0;
      rx_rd_r <= 3'd0;
      spi_miso <= 1'b0;
      frm <= 16'h0000;
      for (int i = 0; i < 128; i++) begin
        mem[i] <= 8'h00;
      end
      mem[A_RX_PHASE] <= ph_init;
    end else if (spi_cs_n && !cs_q) begin
      spi_miso <= ~spi_miso; // released line does not hold its last bit
      cnt_r <= 5'd0;
      if (cnt_r == 5'd16) begin
        frm_valid <= 1'b1;
        frm <= sh_r[15] ? {sh_r[15:8], 8'h00} : sh_r;
        // status registers are read-only
        if (!sh_r[15] && sh_r[14:8] != A_RX_STAT && sh_r[14:8] != A_DL_STAT) begin
          mem[sh_r[14:8]] <= sh_r[7:0];
        end
      end
    end else if (!spi_cs_n) begin
      if (spi_sclk && !sclk_q) begin
        sh_r <= {sh_r[14:0], spi_mosi};
        cnt_r <= cnt_r + 5'd1;
      end
      if (!spi_sclk && sclk_q && cnt_r == 5'd8) begin
        rb_r <= {look[6:0], 1'b0};
        spi_miso <= look[7];
        if (sh_r[7] && sh_r[6:0] == A_DL_STAT) begin
          dll_rd_r <= dll_rd_r + 3'd1;
        end
        if (sh_r[7] && sh_r[6:0] == A_RX_STAT) begin
          rx_rd_r <= rx_rd_r + 3'd1;
        end
      end else if (!spi_sclk && sclk_q && cnt_r > 5'd8 && cnt_r < 5'd16) begin
        spi_miso <= rb_r[7];
        rb_r <= {rb_r[6:0], 1'b0};
      end
    end
  end
endmodule : dls_dev_model

// >>> verification/testbench.sv
// Purpose: self-checking bench for the converter start-up sequencer
// Assumes: device model logs each complete frame; short waits of 20 cycles
// Notes:   every scenario starts from a fresh reset of sequencer and model
`timescale 1ns/10ps
module testbench
  import dls_pkg::*;
;
  localparam int W = 20;
  logic        sys_clk, rst_n, start, data_clk_present, cur_en, mode_en;
  logic [7:0]  cur_lo, cur_hi, mode_val, ph_init;
  logic [1:0]  dll_ok_at, rx_ok_at;
  logic        seq_busy, seq_done, dll_lock_fail, rx_lock_fail;
  logic        spi_cs_n, spi_sclk, spi_mosi, spi_miso, frm_valid;
  logic [15:0] frm;
  logic [15:0] got[$];
  logic [15:0] exp_q[$];
  int          gt[$];
  int          cyc, errors, total_checks;

  dls_init_seq #(.DLL_WAIT_CYC(W), .RX_WAIT_CYC(W)) dls_init_seq_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .start(start), .data_clk_present(data_clk_present), .cur_en(cur_en),
    .cur_lo(cur_lo), .cur_hi(cur_hi), .mode_en(mode_en), .mode_val(mode_val), .seq_busy(seq_busy),
    .seq_done(seq_done), .dll_lock_fail(dll_lock_fail), .rx_lock_fail(rx_lock_fail),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  dls_dev_model dls_dev_model_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .dll_ok_at(dll_ok_at), .rx_ok_at(rx_ok_at), .ph_init(ph_init),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .frm_valid(frm_valid), .frm(frm));

  // clock and frame log
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (frm_valid === 1'b1) begin
      got.push_back(frm);
      gt.push_back(cyc);
    end
  end

  task test_done();
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // expected frame builders
  task ew(input logic [6:0] a, input logic [7:0] d);
    exp_q.push_back({1'b0, a, d});
  endtask : ew
  task er(input logic [6:0] a);
    exp_q.push_back({1'b1, a, 8'h00});
  endtask : er
  task dll_part(input int n);
    ew(A_DL_CFG_A, 8'h44);
    ew(A_DL_CFG_B, 8'h6c);
    for (int i = 0; i < n; i++) begin
      ew(A_DL_CFG_C, 8'hcb);
      ew(A_DL_CTRL, 8'h02);
      ew(A_DL_CTRL, 8'h03);
      er(A_DL_STAT);
    end
  endtask : dll_part
  task rx_try(input logic [7:0] ph);
    if (ph != 8'hff) begin
      er(A_RX_PHASE);
      ew(A_RX_PHASE, ph);
    end
    ew(A_RX_CTRL, 8'h00);
    ew(A_RX_CTRL, 8'h02);
    ew(A_RX_CTRL, 8'h03);
    er(A_RX_STAT);
  endtask : rx_try

  // reset both sides and set the model's behaviour
  task setup(input logic [1:0] dok, input logic [1:0] rok, input logic [7:0] ph, input logic dclk, input logic opt);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    dll_ok_at <= dok;
    rx_ok_at <= rok;
    ph_init <= ph;
    data_clk_present <= dclk;
    cur_en <= opt;
    mode_en <= opt;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    got.delete();
    gt.delete();
    exp_q.delete();
  endtask : setup
  task go_start();
    @(posedge sys_clk);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
  endtask : go_start
  task wait_end();
    for (int i = 0; i < 20000; i++) begin
      @(posedge sys_clk);
      if ((seq_done | dll_lock_fail | rx_lock_fail) === 1'b1) break;
    end
    repeat (10) @(posedge sys_clk);
  endtask : wait_end
  task finish_chk(input logic d, input logic dl, input logic rx);
    chk("frame count", 16'(got.size()), 16'(exp_q.size()));
    for (int i = 0; i < exp_q.size() && i < got.size(); i++) begin
      chk("frame", got[i], exp_q[i]);
    end
    chk("seq_done", 16'(seq_done), 16'(d));
    chk("seq_busy idle", 16'(seq_busy), 16'h0000);
    chk("dll_lock_fail", 16'(dll_lock_fail), 16'(dl));
    chk("rx_lock_fail", 16'(rx_lock_fail), 16'(rx));
  endtask : finish_chk

  // both loops lock at once, optional writes, waits measured
  task t_plain();
    setup(2'd1, 2'd1, 8'h00, 1'b1, 1'b1);
    go_start();
    wait_end();
    dll_part(1);
    ew(A_RX_SKEW, 8'h72);
    rx_try(8'hff);
    ew(A_CUR_LO, 8'h3c);
    ew(A_CUR_HI, 8'h02);
    ew(A_OP_MODE, 8'h01);
    finish_chk(1'b1, 1'b0, 1'b0);
    chk("delay loop wait", 16'(gt[5] - gt[4] >= W + 128), 16'h0001);
    chk("receiver wait", 16'(gt[10] - gt[9] >= W + 128), 16'h0001);
  endtask : t_plain

  // delay loop never locks; a start while busy is ignored
  task t_dll_fail();
    setup(2'd0, 2'd1, 8'h00, 1'b1, 1'b0);
    go_start();
    repeat (60) @(posedge sys_clk);
    chk("seq_busy", 16'(seq_busy), 16'h0001);
    go_start();
    wait_end();
    dll_part(3);
    finish_chk(1'b0, 1'b1, 1'b0);
  endtask : t_dll_fail

  // second delay attempt locks, receiver held for the data clock, phase wraps, mode write only
  task t_retry();
    setup(2'd2, 2'd3, 8'hc5, 1'b0, 1'b0);
    mode_en <= 1'b1;
    go_start();
    for (int i = 0; i < 20000 && got.size() < 10; i++) @(posedge sys_clk);
    repeat (400) @(posedge sys_clk);
    chk("frames before data clock", 16'(got.size()), 16'd10);
    data_clk_present <= 1'b1;
    wait_end();
    dll_part(2);
    ew(A_RX_SKEW, 8'h72);
    rx_try(8'hff);
    rx_try(8'h05);
    rx_try(8'h45);
    ew(A_OP_MODE, 8'h01);
    finish_chk(1'b1, 1'b0, 1'b0);
  endtask : t_retry

  // receiver never locks: no optional writes after the third attempt
  task t_rx_fail();
    setup(2'd1, 2'd0, 8'h00, 1'b1, 1'b1);
    go_start();
    wait_end();
    dll_part(1);
    ew(A_RX_SKEW, 8'h72);
    rx_try(8'hff);
    rx_try(8'h40);
    rx_try(8'h80);
    finish_chk(1'b0, 1'b0, 1'b1);
  endtask : t_rx_fail

  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    data_clk_present = 1'b0;
    cur_en = 1'b0;
    mode_en = 1'b0;
    cur_lo = 8'h3c;
    cur_hi = 8'h02;
    mode_val = 8'h01;
    ph_init = 8'h00;
    dll_ok_at = 2'd1;
    rx_ok_at = 2'd1;
    t_plain();
    t_dll_fail();
    t_retry();
    t_rx_fail();
    test_done();
  end

  // watchdog against a hung sequence
  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    test_done();
  end
endmodule : testbench
